// [logic/sgx_pkg.sv]
/*
  Shared constants and carriers for the timeslot signaling indirect register block.
  Assumes one 100 MHz clock and a byte-wide microprocessor register port.
*/
package sgx_pkg;
  // Direct register offsets
  localparam logic [7:0] REG_BLOCK_CFG  = 8'h40;
  localparam logic [7:0] REG_ACC_STATUS = 8'h41;
  localparam logic [7:0] REG_IND_CTRL   = 8'h42;
  localparam logic [7:0] REG_IND_DATA   = 8'h43;

  // Block configuration and status bit positions, configuration reset value
  localparam int CFG_ACCEL_BIT   = 7;
  localparam int CFG_MASTER_TRUNK_COND_BIT    = 3;
  localparam int CFG_RSVD_BIT    = 2;
  localparam int CFG_IND_BIT     = 1;
  localparam int CFG_PER_TS_FUNC_EN_BIT    = 0;
  localparam int STAT_BUSY_BIT   = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Indirect address ranges
  localparam logic [6:0] IA_SIG_LO_FIRST = 7'h21;
  localparam logic [6:0] IA_SIG_LO_LAST  = 7'h2F;
  localparam logic [6:0] IA_SIG_HI_FIRST = 7'h31;
  localparam logic [6:0] IA_SIG_HI_LAST  = 7'h3F;
  localparam logic [6:0] IA_TCD_FIRST    = 7'h40;
  localparam logic [6:0] IA_TCD_LAST     = 7'h5F;
  localparam logic [6:0] IA_CFG_FIRST    = 7'h60;
  localparam logic [4:0] TS_HALF         = 5'h10;

  // Per-timeslot configuration byte fields
  localparam int TSC_INV_HI   = 7;
  localparam int TSC_INV_LO   = 6;
  localparam int TSC_TKCE_BIT = 5;
  localparam int TSC_DEBE_BIT = 4;
  localparam int TSC_SIG_HI   = 3;

  // Inversion codes and masks; timeslot bit 1 sits in byte bit 7
  localparam logic [1:0] INV_NONE = 2'h0;
  localparam logic [1:0] INV_EVEN = 2'h1;
  localparam logic [1:0] INV_ODD  = 2'h2;
  localparam logic [1:0] INV_ALL  = 2'h3;
  localparam logic [7:0] MASK_EVEN_BITS = 8'h55;
  localparam logic [7:0] MASK_ODD_BITS  = 8'hAA;
  localparam logic [7:0] MASK_ALL_BITS  = 8'hFF;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // Access timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ACCESS_TIME_NS = 480;
  localparam int ACCESS_CYCLES  = ACCESS_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [4:0] ts;
    logic [7:0] pcm;
    logic [3:0] sig;
  } sgx_stream_s;

  typedef struct packed {
    logic       read_not_write;
    logic [6:0] indirect_addr;
  } sgx_ind_ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BUSY = 3'h2,
    ST_DONE = 3'h4
  } sgx_acc_e;
endpackage

// [logic/sgx_ts_proc.sv]
/*
  Per-timeslot output stage: trunk conditioning substitution and PCM inversion.
  Assumes the applied settings are already formed by the caller; purely combinational.
*/
`timescale 1ns/1ps
module sgx_ts_proc (
  input  wire logic [7:0] pcm_in,
  input  wire logic [3:0] sig_in,
  input  wire logic       tc_en,
  input  wire logic [1:0] inv_sel,
  input  wire logic [7:0] trunk_cond_byte,
  input  wire logic [3:0] trunk_cond_sig,
  output logic      [7:0] pcm_out,
  output logic      [3:0] sig_out
);
  logic [7:0] mask;

  always_comb begin
    case (inv_sel)
      sgx_pkg::INV_EVEN: mask = sgx_pkg::MASK_EVEN_BITS;
      sgx_pkg::INV_ODD:  mask = sgx_pkg::MASK_ODD_BITS;
      sgx_pkg::INV_ALL:  mask = sgx_pkg::MASK_ALL_BITS;
      default:           mask = 8'h00;
    endcase
  end

  // Conditioning byte goes out unaltered, any timeslot including 0 and 16
  always_comb begin
    if (tc_en) begin
      pcm_out = trunk_cond_byte;
      sig_out = trunk_cond_sig;
    end else begin
      pcm_out = pcm_in ^ mask;
      sig_out = sig_in;
    end
  end
endmodule // sgx_ts_proc

// [logic/sgx_top.sv]
/*
  Indirect register access path into the signaling extractor plus per-timeslot
  output functions. Assumes a synchronous microprocessor strobe port and a
  byte-per-timeslot receive stream, both on clk; primary option inputs are pins.
*/
`timescale 1ns/1ps
// Behaviour
// - Writing the control register in indirect mode while idle starts one indirect access, whatever the address.
// - read_not_write of 1 reads the addressed register, 0 writes it.
// - Control byte holds read_not_write in bit 7, indirect_addr in bits 6:0.
// - Software loads the data buffer first; a write stores that buffered byte.
// - A completed read leaves the addressed register contents in the data buffer.
// - 21H-2FH are signaling for timeslots 1-15; 31H-3FH for 17-31.
// - 40H-5FH hold one trunk conditioning byte per timeslot 0-31.
// - 60H-7FH hold one configuration and substitute signaling byte per timeslot.
// - Low signaling register n returns timeslot n+16 high nibble, n low.
// - High signaling register n returns timeslot n-16 high nibble, n low.
// - Conditioned timeslots output the conditioning byte, bit 7 first.
// - Timeslots 0 and 16 may also be trunk conditioned.
// - Inversion field: none, even bits, odd bits, or all bits inverted.
// - Conditioning enable substitutes PCM byte and signaling nibble; clear means none.
// - Debounce holds signaling until two consecutive equal samples are seen.
// - Busy is high during an access; software polls it before the next.
// - Per-timeslot settings act only while the per-timeslot function enable is set; master conditioning still uses their trunk byte and signaling nibble.
// - Master trunk conditioning ORs with each per-timeslot conditioning enable.
// - Enabled inversion and debounce settings OR with their pin equivalents.
module sgx_top #(
  parameter int NUM_TS = 32
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic [7:0]           up_addr,
  input  wire logic                 up_wr,
  input  wire logic                 up_rd,
  input  wire logic [7:0]           up_wdata,
  output logic      [7:0]           up_rdata,
  input  wire logic                 rx_valid,
  input  wire sgx_pkg::sgx_stream_s rx_in,
  input  wire logic [1:0]           invert_pin,
  input  wire logic                 debounce_pin,
  output logic                      tx_valid,
  output sgx_pkg::sgx_stream_s      tx_out
);
  localparam int ACC = sgx_pkg::ACCESS_CYCLES;
  localparam logic [6:0] ACC_LOAD = 7'(sgx_pkg::ACCESS_CYCLES - 1);

  logic [7:0]             blk_cfg_q;
  sgx_pkg::sgx_ind_ctrl_s ind_ctrl_q;
  logic [7:0]             dbuf_q;
  sgx_pkg::sgx_acc_e      state_q;
  logic [6:0]             cnt_q;
  logic                   busy;
  logic                   start;
  logic                   done;
  logic [7:0]             tcd_mem [NUM_TS];
  logic [7:0]             cfg_mem [NUM_TS];
  logic [3:0]             sig_q   [NUM_TS];
  logic [3:0]             prev_q  [NUM_TS];
  logic [1:0]             inv_meta_q;
  logic [1:0]             inv_sync_q;
  logic                   deb_meta_q;
  logic                   deb_sync_q;
  logic [6:0]             ia;
  logic [4:0]             ia_ts;
  logic                   in_sig_lo;
  logic                   in_sig_hi;
  logic                   in_tcd;
  logic                   in_cfg;
  logic [7:0]             rd_mux;
  logic                   per_ts_func_en;
  logic                   master_trunk_cond;
  logic [7:0]             ts_cfg;
  logic                   tc_eff;
  logic [1:0]             inv_eff;
  logic                   deb_eff;
  logic [3:0]             sig_next;
  logic [7:0]             pcm_proc;
  logic [3:0]             sig_proc;

  // Pins cross two flops before use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inv_meta_q <= 2'h0;
      inv_sync_q <= 2'h0;
      deb_meta_q <= 1'h0;
      deb_sync_q <= 1'h0;
    end else begin
      inv_meta_q <= invert_pin;
      inv_sync_q <= inv_meta_q;
      deb_meta_q <= debounce_pin;
      deb_sync_q <= deb_meta_q;
    end
  end

  // Indirect access only in indirect mode and while idle
  assign busy  = (state_q != sgx_pkg::ST_IDLE);
  assign start = up_wr && (up_addr == sgx_pkg::REG_IND_CTRL) && !busy
                 && blk_cfg_q[sgx_pkg::CFG_IND_BIT];
  assign done  = (state_q == sgx_pkg::ST_DONE);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blk_cfg_q <= sgx_pkg::CFG_RESET;
    end else if (up_wr && up_addr == sgx_pkg::REG_BLOCK_CFG) begin
      blk_cfg_q <= up_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ind_ctrl_q <= '0;
    end else if (start) begin
      ind_ctrl_q <= up_wdata;
    end
  end

  // A completed read wins over a same-cycle software write of the buffer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dbuf_q <= 8'h00;
    end else if (done && ind_ctrl_q.read_not_write) begin
      dbuf_q <= rd_mux;
    end else if (up_wr && up_addr == sgx_pkg::REG_IND_DATA) begin
      dbuf_q <= up_wdata;
    end
  end

  // Access sequencer: fixed length so busy timing is predictable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= sgx_pkg::ST_IDLE;
      cnt_q   <= 7'h00;
    end else begin
      case (state_q)
        sgx_pkg::ST_IDLE: begin
          if (start) begin
            state_q <= sgx_pkg::ST_BUSY;
            cnt_q   <= ACC_LOAD;
          end
        end
        sgx_pkg::ST_BUSY: begin
          cnt_q <= cnt_q - 7'h01;
          if (cnt_q == 7'h01) begin
            state_q <= sgx_pkg::ST_DONE;
          end
        end
        sgx_pkg::ST_DONE: state_q <= sgx_pkg::ST_IDLE;
        default:          state_q <= sgx_pkg::ST_IDLE;
      endcase
    end
  end

  // Indirect address decode
  assign ia        = ind_ctrl_q.indirect_addr;
  assign ia_ts     = ia[4:0];
  assign in_sig_lo = (ia >= sgx_pkg::IA_SIG_LO_FIRST) && (ia <= sgx_pkg::IA_SIG_LO_LAST);
  assign in_sig_hi = (ia >= sgx_pkg::IA_SIG_HI_FIRST) && (ia <= sgx_pkg::IA_SIG_HI_LAST);
  assign in_tcd    = (ia >= sgx_pkg::IA_TCD_FIRST) && (ia <= sgx_pkg::IA_TCD_LAST);
  assign in_cfg    = (ia >= sgx_pkg::IA_CFG_FIRST);

  always_comb begin
    if (in_sig_lo) begin
      rd_mux = {sig_q[ia_ts + sgx_pkg::TS_HALF], sig_q[ia_ts]};
    end else if (in_sig_hi) begin
      rd_mux = {sig_q[ia_ts - sgx_pkg::TS_HALF], sig_q[ia_ts]};
    end else if (in_tcd) begin
      rd_mux = tcd_mem[ia_ts];
    end else if (in_cfg) begin
      rd_mux = cfg_mem[ia_ts];
    end else begin
      rd_mux = sgx_pkg::READ_UNMAPPED;
    end
  end

  // Signaling registers are read-only; unmapped writes fall through
  always_ff @(posedge clk) begin
    if (done && !ind_ctrl_q.read_not_write && in_tcd) begin
      tcd_mem[ia_ts] <= dbuf_q;
    end
  end

  always_ff @(posedge clk) begin
    if (done && !ind_ctrl_q.read_not_write && in_cfg) begin
      cfg_mem[ia_ts] <= dbuf_q;
    end
  end

  // Applied per-timeslot settings
  assign per_ts_func_en    = blk_cfg_q[sgx_pkg::CFG_PER_TS_FUNC_EN_BIT];
  assign master_trunk_cond    = blk_cfg_q[sgx_pkg::CFG_MASTER_TRUNK_COND_BIT];
  assign ts_cfg  = cfg_mem[rx_in.ts];
  assign tc_eff  = master_trunk_cond || (per_ts_func_en && ts_cfg[sgx_pkg::TSC_TKCE_BIT]);
  assign inv_eff = inv_sync_q | (per_ts_func_en ? ts_cfg[sgx_pkg::TSC_INV_HI:sgx_pkg::TSC_INV_LO] : 2'h0);
  assign deb_eff = deb_sync_q || (per_ts_func_en && ts_cfg[sgx_pkg::TSC_DEBE_BIT]);

  // Debounce keeps the old nibble until two equal samples in a row
  assign sig_next = (!deb_eff || rx_in.sig == prev_q[rx_in.ts]) ? rx_in.sig : sig_q[rx_in.ts];

  always_ff @(posedge clk) begin
    if (rx_valid) begin
      prev_q[rx_in.ts] <= rx_in.sig;
      sig_q[rx_in.ts]  <= sig_next;
    end
  end

  sgx_ts_proc u_proc (
    .pcm_in          (rx_in.pcm),
    .sig_in          (sig_next),
    .tc_en           (tc_eff),
    .inv_sel         (inv_eff),
    .trunk_cond_byte (tcd_mem[rx_in.ts]),
    .trunk_cond_sig  (ts_cfg[sgx_pkg::TSC_SIG_HI:0]),
    .pcm_out         (pcm_proc),
    .sig_out         (sig_proc)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid <= 1'h0;
      tx_out   <= '0;
    end else begin
      tx_valid <= rx_valid;
      if (rx_valid) begin
        tx_out.ts  <= rx_in.ts;
        tx_out.pcm <= pcm_proc;
        tx_out.sig <= sig_proc;
      end
    end
  end

  // Register readback
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_rdata <= 8'h00;
    end else if (up_rd) begin
      case (up_addr)
        sgx_pkg::REG_BLOCK_CFG:  up_rdata <= blk_cfg_q;
        sgx_pkg::REG_ACC_STATUS: up_rdata <= {busy, 7'h00};
        sgx_pkg::REG_IND_CTRL:   up_rdata <= ind_ctrl_q;
        sgx_pkg::REG_IND_DATA:   up_rdata <= dbuf_q;
        default:                 up_rdata <= sgx_pkg::READ_UNMAPPED;
      endcase
    end
  end

  AST_BUSY_ON_START: assert property (@(posedge clk) disable iff (!reset_n) start |=> busy)
    else $error("busy not raised after access start");
  AST_BUSY_LENGTH: assert property (@(posedge clk) disable iff (!reset_n)
    start |-> ##ACC busy ##1 !busy)
    else $error("busy length differs from access time");
  AST_WRITE_TCD: assert property (@(posedge clk) disable iff (!reset_n)
    done && !ind_ctrl_q.read_not_write && in_tcd |=> tcd_mem[$past(ia_ts)] == $past(dbuf_q))
    else $error("indirect write did not store buffered byte");
  AST_READ_BUF: assert property (@(posedge clk) disable iff (!reset_n)
    done && ind_ctrl_q.read_not_write |=> dbuf_q == $past(rd_mux))
    else $error("indirect read did not load data buffer");
  AST_READ_NO_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    done && ind_ctrl_q.read_not_write && in_cfg |=> $stable(cfg_mem[ia_ts]))
    else $error("indirect read altered a register");
  AST_SIG_LO_MAP: assert property (@(posedge clk) disable iff (!reset_n)
    done && ind_ctrl_q.read_not_write && ia == sgx_pkg::IA_SIG_LO_FIRST
    |=> dbuf_q == {$past(sig_q[17]), $past(sig_q[1])})
    else $error("low signaling register layout wrong");
  AST_SIG_HI_MAP: assert property (@(posedge clk) disable iff (!reset_n)
    done && ind_ctrl_q.read_not_write && ia == sgx_pkg::IA_SIG_HI_FIRST
    |=> dbuf_q == {$past(sig_q[1]), $past(sig_q[17])})
    else $error("high signaling register layout wrong");
  AST_TRUNK_OUT: assert property (@(posedge clk) disable iff (!reset_n)
    rx_valid && master_trunk_cond |=> tx_out.pcm == $past(tcd_mem[rx_in.ts]))
    else $error("master trunk conditioning not applied");
  AST_INVERT_ALL: assert property (@(posedge clk) disable iff (!reset_n)
    rx_valid && !tc_eff && per_ts_func_en && ts_cfg[sgx_pkg::TSC_INV_HI:sgx_pkg::TSC_INV_LO] == sgx_pkg::INV_ALL
    |=> tx_out.pcm == ~$past(rx_in.pcm))
    else $error("full inversion not applied");
  AST_NO_FUNC: assert property (@(posedge clk) disable iff (!reset_n)
    rx_valid && !per_ts_func_en && !master_trunk_cond && inv_sync_q == sgx_pkg::INV_NONE |=> tx_out.pcm == $past(rx_in.pcm))
    else $error("per-timeslot function acted while disabled");
  AST_UNMAPPED_WR: assert property (@(posedge clk) disable iff (!reset_n)
    done && !ind_ctrl_q.read_not_write && !in_tcd && !in_cfg |=> $stable(tcd_mem[0]) && $stable(cfg_mem[0]))
    else $error("unmapped write changed state");

  // Refused requests must leave the sequencer alone
  AST_CTRL_REFUSED: assert property (@(posedge clk) disable iff (!reset_n)
    up_wr && up_addr == sgx_pkg::REG_IND_CTRL && busy |=> $stable(ind_ctrl_q))
    else $error("control write accepted while busy");
  AST_IND_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    up_wr && up_addr == sgx_pkg::REG_IND_CTRL && !busy && !blk_cfg_q[sgx_pkg::CFG_IND_BIT] |=> !busy)
    else $error("access started with indirect mode off");
  AST_UNMAPPED_RD: assert property (@(posedge clk) disable iff (!reset_n)
    done && ind_ctrl_q.read_not_write && !in_sig_lo && !in_sig_hi && !in_tcd && !in_cfg
    |=> dbuf_q == sgx_pkg::READ_UNMAPPED)
    else $error("unmapped indirect read value wrong");
  AST_TRUNK_SIG: assert property (@(posedge clk) disable iff (!reset_n)
    rx_valid && tc_eff |=> tx_out.sig == $past(ts_cfg[sgx_pkg::TSC_SIG_HI:0]))
    else $error("substitute signaling not applied");
  AST_DEBOUNCE_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    rx_valid && deb_eff && !tc_eff && rx_in.sig != prev_q[rx_in.ts] |=> tx_out.sig == $past(sig_q[rx_in.ts]))
    else $error("debounce passed an unconfirmed change");

  COV_WRITE: cover property (@(posedge clk) disable iff (!reset_n) done && !ind_ctrl_q.read_not_write && in_cfg);
  COV_READ: cover property (@(posedge clk) disable iff (!reset_n) done && ind_ctrl_q.read_not_write && in_sig_hi);
  COV_TRUNK: cover property (@(posedge clk) disable iff (!reset_n) rx_valid && tc_eff && per_ts_func_en);
  COV_REFUSED: cover property (@(posedge clk) disable iff (!reset_n) up_wr && up_addr == sgx_pkg::REG_IND_CTRL && busy);
endmodule // sgx_top

// [test/sgx_up_model.sv]
/*
  Microprocessor model: direct strobe accesses and indirect access sequences.
  Assumes the strobe port of sgx_top, sampled on the same rising clock edge.
*/
`timescale 1ns/1ps
module sgx_up_model (
  input  wire logic       clk,
  output logic      [7:0] up_addr,
  output logic            up_wr,
  output logic            up_rd,
  output logic      [7:0] up_wdata,
  input  wire logic [7:0] up_rdata
);
  initial begin
    up_addr  = 8'hFF;
    up_wr    = 1'b0;
    up_rd    = 1'b0;
    up_wdata = 8'h00;
  end

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    up_addr  <= a;
    up_wdata <= d;
    up_wr    <= 1'b1;
    @(posedge clk);
    up_wr    <= 1'b0;
    up_addr  <= ~a;  // Released bus shows no stale value
    up_wdata <= ~d;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    up_addr <= a;
    up_rd   <= 1'b1;
    @(posedge clk);
    up_rd   <= 1'b0;
    up_addr <= ~a;
    @(negedge clk);
    d = up_rdata;
  endtask

  // Poll until idle; bounded so a stuck flag cannot hang the run
  task automatic wait_idle(output logic first_busy);
    logic [7:0] s;
    int         n;
    n = 0;
    reg_rd(sgx_pkg::REG_ACC_STATUS, s);
    first_busy = s[sgx_pkg::STAT_BUSY_BIT];
    while (s[sgx_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 100) begin
      reg_rd(sgx_pkg::REG_ACC_STATUS, s);
      n++;
    end
  endtask

  task automatic ind_wr(input logic [6:0] ia, input logic [7:0] d, output logic fb);
    reg_wr(sgx_pkg::REG_IND_DATA, d);
    reg_wr(sgx_pkg::REG_IND_CTRL, {1'b0, ia});
    wait_idle(fb);
  endtask

  task automatic ind_rd(input logic [6:0] ia, output logic [7:0] d, output logic fb);
    reg_wr(sgx_pkg::REG_IND_CTRL, {1'b1, ia});
    wait_idle(fb);
    reg_rd(sgx_pkg::REG_IND_DATA, d);
  endtask
endmodule  // sgx_up_model

// [test/sgx_top_bench.sv]
/*
  Self-checking bench for sgx_top: register and indirect accesses plus stream checks.
  Assumes sgx_up_model drives the strobe port; the bench drives the stream and pins.
*/
`timescale 1ns/1ps
module sgx_top_bench;
  logic                 clk;
  logic                 reset_n;
  logic [7:0]           up_addr;
  logic                 up_wr;
  logic                 up_rd;
  logic [7:0]           up_wdata;
  logic [7:0]           up_rdata;
  logic                 rx_valid;
  sgx_pkg::sgx_stream_s rx_in;
  logic [1:0]           invert_pin;
  logic                 debounce_pin;
  logic                 tx_valid;
  sgx_pkg::sgx_stream_s tx_out;
  int                   failures;
  int                   checked;
  logic [7:0]           d;
  logic                 busy_seen;
  logic [6:0]           ia_t [6] = '{7'h40, 7'h50, 7'h5F, 7'h60, 7'h70, 7'h7F};
  logic [7:0]           dv_t [6] = '{8'hC3, 8'h3C, 8'h5A, 8'hE9, 8'hE9, 8'h00};
  logic [7:0]           msk  [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};

  sgx_top dut (.clk(clk), .reset_n(reset_n), .up_addr(up_addr), .up_wr(up_wr), .up_rd(up_rd),
    .up_wdata(up_wdata), .up_rdata(up_rdata), .rx_valid(rx_valid), .rx_in(rx_in),
    .invert_pin(invert_pin), .debounce_pin(debounce_pin), .tx_valid(tx_valid), .tx_out(tx_out));
  sgx_up_model up (.clk(clk), .up_addr(up_addr), .up_wr(up_wr), .up_rd(up_rd),
    .up_wdata(up_wdata), .up_rdata(up_rdata));

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    up.reg_rd(a, d);
    chk(n, e, d);
  endtask

  task automatic iw(input logic [6:0] ia, input logic [7:0] v);
    logic fb;
    up.ind_wr(ia, v, fb);
    chk("busy_after_write", 8'h01, {7'h00, fb});
    rd(sgx_pkg::REG_ACC_STATUS, 8'h00, "busy_cleared");
  endtask

  task automatic ir(input logic [6:0] ia, input logic [7:0] e);
    logic fb;
    up.ind_rd(ia, d, fb);
    chk("busy_after_read", 8'h01, {7'h00, fb});
    chk("indirect_data", e, d);
    rd(sgx_pkg::REG_ACC_STATUS, 8'h00, "busy_cleared");
  endtask

  // One timeslot through the stream; output lands one cycle later
  task automatic send(input logic [4:0] ts, input logic [7:0] pcm, input logic [3:0] sig,
                      input logic [7:0] ep, input logic [3:0] es);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_in    <= sgx_pkg::sgx_stream_s'({ts, pcm, sig});
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_in    <= sgx_pkg::sgx_stream_s'(~{ts, pcm, sig});
    @(negedge clk);
    chk("tx_valid", 8'h01, {7'h00, tx_valid});
    chk("tx_ts", {3'h0, ts}, {3'h0, tx_out.ts});
    chk("tx_pcm", ep, tx_out.pcm);
    chk("tx_sig", {4'h0, es}, {4'h0, tx_out.sig});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run is a few thousand cycles; generous margin
  initial begin
    #500us;
    failures++;
    tally_and_finish();
  end

  initial begin
    clk          = 1'b0;
    reset_n      = 1'b0;
    rx_valid     = 1'b0;
    rx_in        = '0;
    invert_pin   = 2'b00;
    debounce_pin = 1'b0;
    failures     = 0;
    checked      = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h40, 8'h00, "cfg_reset");
    rd(8'h41, 8'h00, "status_reset");
    rd(8'h44, 8'h00, "direct_unmapped");
    up.reg_wr(8'h40, 8'h01);
    up.reg_wr(8'h42, 8'hC0);
    rd(8'h41, 8'h00, "status_ind_off");
    rd(8'h42, 8'h00, "ctrl_ind_off");
    up.reg_wr(8'h40, 8'h03);
    rd(8'h40, 8'h03, "cfg_readback");
    $display("test direct done");
    foreach (ia_t[i]) iw(ia_t[i], dv_t[i]);
    foreach (ia_t[i]) ir(ia_t[i], dv_t[i]);
    ir(7'h30, 8'h00);
    up.reg_wr(8'h42, 8'hC0);
    up.reg_wr(8'h42, 8'hD0);
    up.wait_idle(busy_seen);
    chk("busy_seen", 8'h01, {7'h00, busy_seen});
    rd(8'h42, 8'hC0, "ctrl_busy_refused");
    rd(8'h43, 8'hC3, "read_after_refused");
    $display("test indirect done");
    send(5'h00, 8'h12, 4'h5, 8'hC3, 4'h9);
    send(5'h10, 8'h12, 4'h5, 8'h3C, 4'h9);
    $display("test trunk done");
    iw(7'h42, 8'hA5);
    for (int k = 0; k < 4; k++) begin
      iw(7'h62, {k[1:0], 6'h00});
      send(5'h02, 8'h0F, 4'h6, 8'h0F ^ msk[k], 4'h6);
    end
    $display("test invert done");
    iw(7'h61, 8'h00);
    iw(7'h71, 8'h00);
    send(5'h01, 8'h00, 4'h3, 8'h00, 4'h3);
    send(5'h11, 8'h00, 4'hC, 8'h00, 4'hC);
    ir(7'h21, 8'hC3);
    ir(7'h31, 8'h3C);
    iw(7'h21, 8'h77);
    ir(7'h21, 8'hC3);
    $display("test signaling done");
    up.reg_wr(8'h40, 8'h02);
    send(5'h02, 8'h0F, 4'h6, 8'h0F, 4'h6);
    send(5'h00, 8'h12, 4'h5, 8'h12, 4'h5);
    up.reg_wr(8'h40, 8'h0A);
    send(5'h02, 8'h0F, 4'h6, 8'hA5, 4'h0);
    $display("test enables done");
    up.reg_wr(8'h40, 8'h02);
    invert_pin <= 2'b10;
    repeat (4) @(posedge clk);
    send(5'h02, 8'h0F, 4'h6, 8'hA5, 4'h6);
    up.reg_wr(8'h40, 8'h03);
    iw(7'h62, 8'h40);
    send(5'h02, 8'h0F, 4'h6, 8'hF0, 4'h6);
    invert_pin   <= 2'b00;
    debounce_pin <= 1'b1;
    repeat (4) @(posedge clk);
    send(5'h02, 8'h0F, 4'h9, 8'h5A, 4'h6);
    send(5'h02, 8'h0F, 4'h9, 8'h5A, 4'h9);
    debounce_pin <= 1'b0;
    iw(7'h62, 8'h10);
    send(5'h02, 8'h0F, 4'h3, 8'h0F, 4'h9);
    send(5'h02, 8'h0F, 4'h3, 8'h0F, 4'h3);
    $display("test pins done");
    tally_and_finish();
  end
endmodule  // sgx_top_bench
